/* File: design/cdas_stage.sv */
// Distortion alarm stage: elements, blocking, events and fault history
// Operation
// [R1] Blocking input is sampled at each program-cycle start, before pick-up evaluation.
// [R2] Pick-up with blocking inactive raises start and starts definite-time timing.
// [R3] Pick-up with blocking active raises blocked only; no start, no timing.
// [R4] Blocking after start drops start through the normal release path.
// [R5] Each blocking gives a display pulse and a blocked event with data.
// [R6] In forcing test mode a software switch replaces the blocking input.
// [R7] Blocking source asserts at least 5 ms before the alarm delay expires.
// [R8] Alarm follows start after a fixed delay, regardless of overshoot.
// [R9] Each element has its own delay, 0 to 1800 s, 5 ms steps, default 10 s.
// [R10] Events for start, alarm, blocked; per-event ON and OFF selection.
// [R11] Fourteen event codes: start/alarm per element ON/OFF, blocked ON/OFF.
// [R12] Events carry a time stamp and process data of the transition.
// [R13] Twelve-record history, ON transitions only, oldest overwritten first.
// [R14] Record holds time, event, per-phase distortion and setting group.
// [R15] Pick-up when distortion exceeds limit; any phase suffices for phase group.
// [R16] Release only below 97 percent of the limit; fixed hysteresis.
// [R17] Per-element alarm disable; a disabled element never alarms.
// [R18] Condition code 0 normal, 1 start, 2 alarm, 3 blocked.
// [R19] Alarm when timer expires with start held; timer and alarm clear on drop.
// [R20] Timer counts program cycles against delay in program-cycle steps.
`timescale 1ns/10ps
`default_nettype none
module cdas_stage
   import cdas_pkg::*;
#(
   parameter int unsigned CYCLE_LEN = CYCLE_CLKS
)(
   // Clock and reset
   input  wire logic          i_mclk,
   input  wire logic          i_rst_n,
   // Register port
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [31:0]   i_wdata,
   input  wire logic          i_wr,
   input  wire logic          i_rd,
   output logic [31:0]        o_rdata,
   // Measurement and system inputs
   input  wire logic [DW-1:0] i_dist_l1,
   input  wire logic [DW-1:0] i_dist_l2,
   input  wire logic [DW-1:0] i_dist_l3,
   input  wire logic [DW-1:0] i_dist_first_residual_input,
   input  wire logic [DW-1:0] i_dist_second_residual_input,
   input  wire logic          i_block,
   input  wire logic [31:0]   i_time_ms,
   input  wire logic [2:0]    i_active_setting_group,
   // Stage outputs
   output logic [NEL-1:0]     o_start,
   output logic [NEL-1:0]     o_alarm,
   output logic               o_blocked,
   output logic [1:0]         o_monitor_condition_code,
   output logic               o_hmi_notify,
   // Event stream to the relay event buffer
   output logic               o_evt_valid,
   output logic [3:0]         o_evt_code,
   output logic [31:0]        o_evt_time,
   output logic [DW-1:0]      o_evt_l1,
   output logic [DW-1:0]      o_evt_l2,
   output logic [DW-1:0]      o_evt_l3,
   output logic [NEL-1:0]     o_evt_fault
);
   // ==========================================================
   // Program cycle tick
   logic [31:0] cyc_cnt_r;
   logic        tick_r, eval_r;
   wire         cyc_wrap = cyc_cnt_r == 32'(CYCLE_LEN - 1);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cyc_cnt_r <= '0;
         tick_r    <= 1'b0;
         eval_r    <= 1'b0;
      end else begin
         cyc_cnt_r <= cyc_wrap ? '0 : cyc_cnt_r + 1'b1;
         tick_r    <= cyc_wrap;
         eval_r    <= tick_r;
      end
   end

   // ==========================================================
   // Blocking input: three-stage synchroniser, accept when stages 2 and 3 agree
   logic blk_s1_r, blk_s2_r, blk_s3_r, blk_lvl_r, blk_samp_r;
   logic force_en_r, force_sw_r;
   wire  blk_eff = force_en_r ? force_sw_r : blk_lvl_r;            // R6

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         blk_s1_r   <= 1'b0;
         blk_s2_r   <= 1'b0;
         blk_s3_r   <= 1'b0;
         blk_lvl_r  <= 1'b0;
         blk_samp_r <= 1'b0;
      end else begin
         blk_s1_r  <= i_block;
         blk_s2_r  <= blk_s1_r;
         blk_s3_r  <= blk_s2_r;
         blk_lvl_r <= (blk_s2_r == blk_s3_r) ? blk_s2_r : blk_lvl_r;
         // Sampled once, one clock ahead of element evaluation
         if (tick_r) begin
            blk_samp_r <= blk_eff;                                 // R1
         end
      end
   end

   // ==========================================================
   // Settings registers
   logic [NEL-1:0] alm_dis_r;
   logic [NEV-1:0] evsel_r;
   logic [DW-1:0]  lim_r [NEL];
   logic [TW-1:0]  dly_r [NEL];
   logic [3:0]     hsel_r;
   wire  [TW-1:0]  wr_dly = (i_wdata[TW-1:0] > DLY_MAX) ? DLY_MAX : i_wdata[TW-1:0]; // R9

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         force_en_r <= 1'b0;
         force_sw_r <= 1'b0;
         alm_dis_r  <= '0;
         evsel_r    <= EVSEL_RST;
         hsel_r     <= '0;
         for (int k = 0; k < NEL; k++) begin
            lim_r[k] <= LIM_RST;
            dly_r[k] <= DLY_RST;                                   // R9
         end
      end else if (i_wr) begin
         if (i_addr == REG_CTRL) begin
            force_en_r <= i_wdata[CTRL_FORCE_EN];
            force_sw_r <= i_wdata[CTRL_FORCE_SW];
         end
         if (i_addr == REG_ALM_DIS) begin
            alm_dis_r <= i_wdata[NEL-1:0];
         end
         if (i_addr == REG_EVSEL) begin
            evsel_r <= i_wdata[NEV-1:0];                           // R10
         end
         if (i_addr == REG_HIST_SEL) begin
            hsel_r <= i_wdata[3:0];
         end
         for (int k = 0; k < NEL; k++) begin
            if (i_addr == REG_LIM0 + AW'(4 * k)) begin
               lim_r[k] <= i_wdata[DW-1:0];
            end
            if (i_addr == REG_DLY0 + AW'(4 * k)) begin
               dly_r[k] <= wr_dly;
            end
         end
      end
   end

   // ==========================================================
   // Elements
   wire [DW-1:0] max_l12 = (i_dist_l1 > i_dist_l2) ? i_dist_l1 : i_dist_l2;
   wire [DW-1:0] max_ph  = (max_l12 > i_dist_l3) ? max_l12 : i_dist_l3;   // R15
   wire [DW-1:0] el_dist [NEL];
   wire [NEL-1:0] el_start, el_alarm, el_blk;

   assign el_dist[0] = max_ph;
   assign el_dist[1] = i_dist_first_residual_input;
   assign el_dist[2] = i_dist_second_residual_input;

   for (genvar g = 0; g < NEL; g++) begin : g_el
      cdas_elem u_elem (
         .i_mclk      (i_mclk),
         .i_rst_n     (i_rst_n),
         .i_eval      (eval_r),
         .i_block     (blk_samp_r),
         .i_dist      (el_dist[g]),
         .i_limit     (lim_r[g]),
         .i_delay     (dly_r[g]),
         .i_alarm_dis (alm_dis_r[g]),
         .o_start     (el_start[g]),
         .o_alarm     (el_alarm[g]),
         .o_blocked   (el_blk[g])
      );
   end

   wire        any_blk = |el_blk;
   logic [1:0] cond;
   assign cond = any_blk   ? COND_BLOCKED :
                 |el_alarm ? COND_ALARM   :
                 |el_start ? COND_START   : COND_NORMAL;           // R18

   // ==========================================================
   // Event detection and serialisation
   wire  [6:0]     sig_now = {any_blk, el_alarm, el_start};
   logic [6:0]     sig_prev_r;
   logic [NEV-1:0] pend_r, ev_new;
   logic [DW-1:0]  snap_r [NEL];
   wire  [NEV-1:0] grant = pend_r & (~pend_r + 1'b1);
   logic [3:0]     gcode;

   always_comb begin
      ev_new = '0;
      for (int s = 0; s < 7; s++) begin
         ev_new[2*s]   = sig_now[s] && !sig_prev_r[s];             // R11
         ev_new[2*s+1] = !sig_now[s] && sig_prev_r[s];
      end
   end

   always_comb begin
      gcode = '0;
      for (int e = 0; e < NEV; e++) begin
         if (grant[e]) begin
            gcode = 4'(e);
         end
      end
   end

   wire           is_on   = !gcode[0];
   wire [2:0]     gsig    = gcode[3:1];
   wire [NEL-1:0] el_hot  = (gsig == 3'h0 || gsig == 3'h3) ? 3'h1 :
                            (gsig == 3'h1 || gsig == 3'h4) ? 3'h2 : 3'h4;
   wire [NEL-1:0] g_fault = (gsig == 3'h6) ? el_blk : el_hot;     // R5
   wire           emit    = |pend_r;
   wire           hwr     = emit && is_on;                         // R13

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         sig_prev_r <= '0;
         pend_r     <= '0;
         for (int k = 0; k < NEL; k++) begin
            snap_r[k] <= '0;
         end
      end else begin
         sig_prev_r <= sig_now;
         // New edges win over the grant of the same cycle
         pend_r     <= (pend_r & ~grant) | ev_new;
         if (eval_r) begin
            snap_r[0] <= i_dist_l1;                                // R12
            snap_r[1] <= i_dist_l2;
            snap_r[2] <= i_dist_l3;
         end
      end
   end

   // ==========================================================
   // Outputs and event port
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_start                  <= '0;
         o_alarm                  <= '0;
         o_blocked                <= 1'b0;
         o_monitor_condition_code <= COND_NORMAL;
         o_hmi_notify             <= 1'b0;
         o_evt_valid              <= 1'b0;
         o_evt_code               <= '0;
         o_evt_time               <= '0;
         o_evt_l1                 <= '0;
         o_evt_l2                 <= '0;
         o_evt_l3                 <= '0;
         o_evt_fault              <= '0;
      end else begin
         o_start                  <= el_start;
         o_alarm                  <= el_alarm;
         o_blocked                <= any_blk;
         o_monitor_condition_code <= cond;
         o_hmi_notify             <= emit && gcode == EV_BLK_ON;   // R5
         o_evt_valid              <= emit && evsel_r[gcode];       // R10
         if (emit) begin
            o_evt_code  <= gcode;
            o_evt_time  <= i_time_ms;                              // R12
            o_evt_l1    <= snap_r[0];
            o_evt_l2    <= snap_r[1];
            o_evt_l3    <= snap_r[2];
            o_evt_fault <= g_fault;
         end
      end
   end

   // ==========================================================
   // Fault history ring
   logic [31:0]   h_ts   [HIST_DEPTH];
   logic [3:0]    h_code [HIST_DEPTH];
   logic [2:0]    h_sg   [HIST_DEPTH];
   logic [DW-1:0] h_l1   [HIST_DEPTH];
   logic [DW-1:0] h_l2   [HIST_DEPTH];
   logic [DW-1:0] h_l3   [HIST_DEPTH];
   logic [3:0]    hwp_r, hcnt_r;
   wire  [4:0]    hraw = 5'(hwp_r) + 5'(HIST_DEPTH - 1) - 5'(hsel_r);
   wire  [3:0]    hidx = (hraw >= 5'(HIST_DEPTH)) ? 4'(hraw - 5'(HIST_DEPTH)) : hraw[3:0];
   wire           hok  = hsel_r < hcnt_r;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         hwp_r  <= '0;
         hcnt_r <= '0;
      end else if (hwr) begin
         hwp_r  <= (hwp_r == 4'(HIST_DEPTH - 1)) ? '0 : hwp_r + 1'b1;   // R13
         hcnt_r <= (hcnt_r == 4'(HIST_DEPTH)) ? hcnt_r : hcnt_r + 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (hwr) begin
         h_ts[hwp_r]   <= i_time_ms;                               // R14
         h_code[hwp_r] <= gcode;
         h_sg[hwp_r]   <= i_active_setting_group;
         h_l1[hwp_r]   <= snap_r[0];
         h_l2[hwp_r]   <= snap_r[1];
         h_l3[hwp_r]   <= snap_r[2];
      end
   end

   // ==========================================================
   // Read mux; unmapped addresses read zero
   wire [31:0] st_word = {21'h0, 2'(cond), el_blk, el_alarm, el_start};
   wire [31:0] hb_word = {11'h0, h_sg[hidx], h_code[hidx], h_l3[hidx]};
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      case (i_addr)
         REG_CTRL:     rd_mux = {30'h0, force_sw_r, force_en_r};
         REG_ALM_DIS:  rd_mux = {29'h0, alm_dis_r};
         REG_EVSEL:    rd_mux = {18'h0, evsel_r};
         REG_LIM0:     rd_mux = {18'h0, lim_r[0]};
         8'h10:        rd_mux = {18'h0, lim_r[1]};
         8'h14:        rd_mux = {18'h0, lim_r[2]};
         REG_DLY0:     rd_mux = {13'h0, dly_r[0]};
         8'h1C:        rd_mux = {13'h0, dly_r[1]};
         8'h20:        rd_mux = {13'h0, dly_r[2]};
         REG_STATUS:   rd_mux = st_word;
         REG_HIST_SEL: rd_mux = {28'h0, hsel_r};
         REG_HIST_TS:  rd_mux = hok ? h_ts[hidx] : 32'h0;
         REG_HIST_A:   rd_mux = hok ? {4'h0, h_l2[hidx], h_l1[hidx]} : 32'h0;
         REG_HIST_B:   rd_mux = hok ? hb_word : 32'h0;
         REG_HIST_CNT: rd_mux = {28'h0, hcnt_r};
         default:      rd_mux = '0;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= i_rd ? rd_mux : 32'h0;
      end
   end

   // ==========================================================
   // Assertions
   AST_BLK_SAMPLE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R1
      tick_r |=> eval_r && blk_samp_r == $past(blk_eff))
      else $error("blocking not sampled before evaluation");
   AST_FORCE_SW: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R6
      tick_r && force_en_r |=> blk_samp_r == $past(force_sw_r))
      else $error("forcing switch did not drive blocking");
   AST_HMI_BLK: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R5
      o_hmi_notify |-> o_evt_code == EV_BLK_ON && o_evt_fault != '0)
      else $error("display pulse without blocked event");
   AST_EVT_CODE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R11
      o_evt_valid |-> o_evt_code < 4'(NEV))
      else $error("event code out of range");
   AST_EVT_SEL: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R10
      o_evt_valid |-> $past(evsel_r[gcode]) && $past(emit))
      else $error("unselected event emitted");
   AST_HIST_CNT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R13
      hwr && hcnt_r == 4'(HIST_DEPTH) |=> hcnt_r == 4'(HIST_DEPTH))
      else $error("history count left twelve");
   AST_COND: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R18
      any_blk |=> o_monitor_condition_code == COND_BLOCKED)
      else $error("condition code not blocked");
   COV_ALARM: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_alarm[0]));
   COV_BLOCKED: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_hmi_notify);
   COV_HIST_WRAP: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      hwr && hcnt_r == 4'(HIST_DEPTH));
endmodule
`default_nettype wire

/* File: design/cdas_pkg.sv */
// Constants, register map and codes for the distortion alarm stage
package cdas_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned MCLK_HZ       = 20_000_000;
   localparam int unsigned CYCLE_US      = 5000;
   localparam int unsigned CYCLE_CLKS    = MCLK_HZ / 1_000_000 * CYCLE_US;
   // Blocking lead time the blocking matrix must honour before delay expiry
   localparam int unsigned BLOCK_LEAD_US = 5000;
   localparam int unsigned DLY_MAX_S     = 1800;
   localparam int unsigned DLY_MAX_STEPS = DLY_MAX_S * 1_000_000 / CYCLE_US;
   localparam int unsigned DLY_RST_MS    = 10_000;

   // ==========================================================
   // Widths and reset values
   localparam int unsigned DW        = 14;   // Distortion, 0.01 % units
   localparam int unsigned TW        = 19;   // Delay, program-cycle steps
   localparam int unsigned AW        = 8;
   localparam int unsigned NEL       = 3;
   localparam int unsigned NEV       = 14;
   localparam int unsigned HIST_DEPTH = 12;
   localparam logic [DW-1:0] LIM_RST = 14'h03E8;
   localparam logic [TW-1:0] DLY_RST = TW'(DLY_RST_MS * 1000 / CYCLE_US);
   localparam logic [TW-1:0] DLY_MAX = TW'(DLY_MAX_STEPS);
   localparam logic [6:0]    HYST_NUM = 7'h61;   // Release at 97 %
   localparam logic [6:0]    HYST_DEN = 7'h64;
   localparam logic [NEV-1:0] EVSEL_RST = 14'h3FFF;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [AW-1:0] REG_CTRL     = 8'h00;
   localparam logic [AW-1:0] REG_ALM_DIS  = 8'h04;
   localparam logic [AW-1:0] REG_EVSEL    = 8'h08;
   localparam logic [AW-1:0] REG_LIM0     = 8'h0C;
   localparam logic [AW-1:0] REG_DLY0     = 8'h18;
   localparam logic [AW-1:0] REG_STATUS   = 8'h24;
   localparam logic [AW-1:0] REG_HIST_SEL = 8'h28;
   localparam logic [AW-1:0] REG_HIST_TS  = 8'h2C;
   localparam logic [AW-1:0] REG_HIST_A   = 8'h30;
   localparam logic [AW-1:0] REG_HIST_B   = 8'h34;
   localparam logic [AW-1:0] REG_HIST_CNT = 8'h38;

   // Field positions
   localparam int unsigned CTRL_FORCE_EN = 0;
   localparam int unsigned CTRL_FORCE_SW = 1;
   localparam int unsigned ST_START_LSB  = 0;
   localparam int unsigned ST_ALARM_LSB  = 3;
   localparam int unsigned ST_BLK_LSB    = 6;
   localparam int unsigned ST_COND_LSB   = 9;
   localparam int unsigned HB_CODE_LSB   = 14;
   localparam int unsigned HB_SG_LSB     = 18;

   // ==========================================================
   // Codes
   typedef enum logic [1:0] {
      COND_NORMAL  = 2'b00,
      COND_START   = 2'b01,
      COND_ALARM   = 2'b10,
      COND_BLOCKED = 2'b11
   } cdas_cond_t;

   // Event code = 2 * signal + (1 for OFF); signals: start ph/r1/r2,
   // alarm ph/r1/r2, blocked
   localparam logic [3:0] EV_START_PH_ON = 4'h0;
   localparam logic [3:0] EV_ALARM_PH_ON = 4'h6;
   localparam logic [3:0] EV_BLK_ON      = 4'hC;
   localparam logic [3:0] EV_BLK_OFF     = 4'hD;
endpackage

/* File: design/cdas_elem.sv */
// One alarm element: hysteresis pick-up, blocking check and definite-time timer
`timescale 1ns/10ps
`default_nettype none
module cdas_elem
   import cdas_pkg::*;
(
   // Clock and reset
   input  wire logic          i_mclk,
   input  wire logic          i_rst_n,
   // Program-cycle evaluation and settings
   input  wire logic          i_eval,
   input  wire logic          i_block,
   input  wire logic [DW-1:0] i_dist,
   input  wire logic [DW-1:0] i_limit,
   input  wire logic [TW-1:0] i_delay,
   input  wire logic          i_alarm_dis,
   // Element outputs
   output logic               o_start,
   output logic               o_alarm,
   output logic               o_blocked
);
   logic          pu_r, start_r, alarm_r, blk_r;
   logic          pu_nxt, start_nxt, alarm_nxt, blk_nxt;
   logic [TW-1:0] tmr_r, tmr_nxt, tmr_inc;
   wire  [20:0]   dist_x = 21'(i_dist) * 21'(HYST_DEN);
   wire  [20:0]   lim_x  = 21'(i_limit) * 21'(HYST_NUM);
   wire           exceed = i_dist > i_limit;                       // R15
   wire           below  = dist_x < lim_x;                         // R16
   wire           rise   = pu_nxt && !pu_r;

   assign pu_nxt  = pu_r ? !below : exceed;                        // R16
   assign tmr_inc = (tmr_r == DLY_MAX) ? tmr_r : tmr_r + 1'b1;     // R20

   always_comb begin
      start_nxt = start_r;
      alarm_nxt = alarm_r;
      blk_nxt   = blk_r;
      tmr_nxt   = tmr_r;
      if (!pu_nxt) begin
         start_nxt = 1'b0;
         alarm_nxt = 1'b0;
         blk_nxt   = 1'b0;
         tmr_nxt   = '0;
      end else if (rise) begin
         start_nxt = !i_block;                                     // R2 R3
         blk_nxt   = i_block;                                      // R3
         alarm_nxt = 1'b0;
         tmr_nxt   = '0;
      end else if (start_r && i_block) begin
         // Clears start, alarm and timer as a cleared pick-up does, but sets blocked
         start_nxt = 1'b0;                                         // R4
         alarm_nxt = 1'b0;
         blk_nxt   = 1'b1;
         tmr_nxt   = '0;
      end else if (start_r) begin
         tmr_nxt   = tmr_inc;                                      // R8 R19
         alarm_nxt = !i_alarm_dis && (tmr_inc >= i_delay);         // R17 R19
      end else if (blk_r && !i_block) begin
         // Blocked pick-up is not re-processed until it clears
         blk_nxt   = 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         pu_r    <= 1'b0;
         start_r <= 1'b0;
         alarm_r <= 1'b0;
         blk_r   <= 1'b0;
         tmr_r   <= '0;
      end else if (i_eval) begin
         pu_r    <= pu_nxt;
         start_r <= start_nxt;
         alarm_r <= alarm_nxt;
         blk_r   <= blk_nxt;
         tmr_r   <= tmr_nxt;
      end
   end

   assign o_start   = start_r;
   assign o_alarm   = alarm_r;
   assign o_blocked = blk_r;

   // ==========================================================
   // Assertions
   AST_START_RISE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R2
      i_eval && rise && !i_block |=> start_r && !blk_r)
      else $error("start not raised on unblocked pick-up");
   AST_BLK_RISE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R3
      i_eval && rise && i_block |=> blk_r && !start_r && tmr_r == '0)
      else $error("blocked pick-up started timing");
   AST_BLK_LATE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R4
      i_eval && start_r && i_block |=> !start_r && !alarm_r && tmr_r == '0)
      else $error("late blocking did not release start");
   AST_ALARM_DT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R19
      $rose(alarm_r) |-> $past(start_r) && start_r && tmr_r >= i_delay)
      else $error("alarm without expired delay");
   AST_ALARM_DIS: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R17
      $rose(alarm_r) |-> $past(!i_alarm_dis))
      else $error("disabled element raised alarm");
   AST_HYST_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R16
      i_eval && pu_r && !below |=> pu_r)
      else $error("pick-up released above 97 percent");
endmodule
`default_nettype wire

/* File: testbench/cdas_far_model.sv */
// Far-side model: blocking source and relay event buffer
`timescale 1ns/10ps
`default_nettype none
module cdas_far_model
   import cdas_pkg::*;
(
   // Clock
   input  wire logic       i_mclk,
   // Bench command and stage events
   input  wire logic       i_blk_req,
   input  wire logic       i_evt_valid,
   input  wire logic [3:0] i_evt_code,
   // Blocking level and last stored event
   output logic            o_block,
   output logic [3:0]      o_last_code
);
   // ==========================================================
   // Blocking level follows the bench request one clock later
   always_ff @(posedge i_mclk) o_block <= i_blk_req;
   // Only selected events reach the buffer
   always_ff @(posedge i_mclk) if (i_evt_valid) o_last_code <= i_evt_code;
endmodule
`default_nettype wire

/* File: testbench/current_distortion_alarm_stage_bench.sv */
// Self-checking bench for the distortion alarm stage
`timescale 1ns/10ps
`default_nettype none
module current_distortion_alarm_stage_bench
   import cdas_pkg::*;
;
   // ==========================================================
   // Signals
   logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, blk_req = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, tms = 32'h0;
   logic [DW-1:0] dl2 = 14'h0000, dr1 = 14'h0000;
   logic block;
   logic [3:0] last_code;
   int bad_count = 0, check_count = 0, hmi_n = 0;
   wire logic evt_v, bk_o, hmi;
   wire logic [3:0] evt_c;
   wire logic [1:0] cc_o;
   wire logic [2:0] st_o, al_o;
   initial forever #25 clk = ~clk;
   always_ff @(posedge clk) tms <= tms + 32'h1;
   // Display pulses are counted so that a missing or doubled one shows up
   always_ff @(posedge clk) if (hmi) hmi_n <= hmi_n + 1;
   cdas_stage #(.CYCLE_LEN(32)) u_dut (.i_mclk(clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_dist_l1(14'h0000),
      .i_dist_l2(dl2), .i_dist_l3(14'h0000), .i_dist_first_residual_input(dr1),
      .i_dist_second_residual_input(14'h0000), .i_block(block), .i_time_ms(tms),
      .i_active_setting_group(3'h2), .o_start(st_o), .o_alarm(al_o), .o_blocked(bk_o),
      .o_monitor_condition_code(cc_o), .o_hmi_notify(hmi), .o_evt_valid(evt_v),
      .o_evt_code(evt_c), .o_evt_time(), .o_evt_l1(), .o_evt_l2(), .o_evt_l3(),
      .o_evt_fault());
   cdas_far_model u_far (.i_mclk(clk), .i_blk_req(blk_req), .i_evt_valid(evt_v),
      .i_evt_code(evt_c), .o_block(block), .o_last_code(last_code));
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a; wdata <= d; wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      addr <= a; rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk("rdata", rdata, e);
      @(posedge clk);
   endtask
   task automatic cyc(input int n);
      repeat (n * 32) @(posedge clk);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================
   // Sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(REG_DLY0, 32'(DLY_RST));
      rd(REG_EVSEL, 32'(EVSEL_RST));
      rd(8'hFC, 32'h0);
      $display("test defaults done");
      wr(REG_DLY0, 32'h4);
      dl2 <= 14'h03E9;
      cyc(2);
      rd(REG_STATUS, 32'h201);
      chk("event", 32'(last_code), 32'(EV_START_PH_ON));
      cyc(5);
      rd(REG_STATUS, 32'h409);
      dl2 <= 14'h03D4;
      cyc(2);
      rd(REG_STATUS, 32'h409);
      dl2 <= 14'h03C0;
      cyc(2);
      rd(REG_STATUS, 32'h0);
      $display("test timing done");
      dl2 <= 14'h03E9;
      cyc(2);
      blk_req <= 1'b1;
      cyc(2);
      rd(REG_STATUS, 32'h640);
      chk("event", 32'(last_code), 32'(EV_BLK_ON));
      blk_req <= 1'b0;
      dl2 <= 14'h0000;
      cyc(2);
      wr(REG_CTRL, 32'h3);
      dl2 <= 14'h03E9;
      cyc(2);
      rd(REG_STATUS, 32'h640);
      wr(REG_CTRL, 32'h0);
      cyc(2);
      rd(REG_STATUS, 32'h0);
      $display("test blocking done");
      dl2 <= 14'h0000;
      wr(REG_ALM_DIS, 32'h1);
      wr(REG_DLY0 + 8'h04, 32'h0);
      cyc(2);
      dl2 <= 14'h03E9;
      dr1 <= 14'h03E9;
      cyc(7);
      rd(REG_STATUS, 32'h413);
      chk("outs", 32'({cc_o, bk_o, al_o, st_o}), 32'h113);
      rd(REG_HIST_CNT, 32'h8);
      rd(REG_HIST_A, 32'h00FA4000);
      rd(REG_HIST_B, 32'h000A0000);
      chk("hmi", 32'(hmi_n), 32'h2);
      $display("test disable done");
      end_of_test();
   end
endmodule
`default_nettype wire
